// ---- inc/fdc_pkg.sv ----
package fdc_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int STEP_W = 16;
    localparam int NUM_W = 16;
    localparam int FRAME_BITS = ADDR_W + DATA_W;
    localparam int LEVELS_MAX = 8;
    localparam int FIFO_DEPTH = 8;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_BANK_A = 8'h09;
    localparam logic [ADDR_W-1:0] ADDR_BANK_B = 8'h19;
    localparam logic [ADDR_W-1:0] ADDR_DIRECT = 8'h21;
    localparam logic [ADDR_W-1:0] ADDR_DEV_SEL = 8'h22;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h23;
    localparam logic [ADDR_W-1:0] ADDR_NOM_A = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_NOM_B = 8'h25;

    localparam int CTRL_SET_SEL_BIT = 6;
    localparam int MODE_LO_BIT = 0;
    localparam int MODE_HI_BIT = 1;
    localparam int LEVEL_LSB = 2;
    localparam int LEVEL_MSB = 4;
    localparam int EN_A_BIT = 5;
    localparam int EN_B_BIT = 6;
    localparam int DEV_SEL_MSB = 2;

    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int GAP_CYC = 4 * LINK_HALF_CYC;
    localparam int DRAIN_CYC = 256;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        FDC_MODE_PIN = 2'h0,
        FDC_MODE_REG = 2'h1,
        FDC_MODE_STREAM = 2'h2,
        FDC_MODE_DIRECT = 2'h3
    } fdc_mode_e;

    typedef enum logic [1:0] {
        FDC_TX_IDLE = 2'b00,
        FDC_TX_LOW = 2'b01,
        FDC_TX_HIGH = 2'b11,
        FDC_TX_END = 2'b10
    } fdc_tx_state_e;

endpackage : fdc_pkg

// ---- inc/fdc_link_if.sv ----
`timescale 1ns/10ps
interface fdc_link_if;
    logic ser_clk;
    logic ser_data;
    logic ser_cs_n;
    logic symbol_pin_0;
    logic symbol_pin_1;
    logic stream_clk;
    logic stream_ws;
    logic stream_ready;

    modport host (
        output ser_clk,
        output ser_data,
        output ser_cs_n,
        output symbol_pin_0,
        output symbol_pin_1,
        output stream_clk,
        output stream_ws,
        input stream_ready
    );

    modport dev (
        input ser_clk,
        input ser_data,
        input ser_cs_n,
        input symbol_pin_0,
        input symbol_pin_1,
        input stream_clk,
        input stream_ws,
        output stream_ready
    );
endinterface : fdc_link_if

// ---- rtl/fdc_fifo.sv ----
`timescale 1ns/10ps
module fdc_fifo #(
    parameter int WIDTH = fdc_pkg::STEP_W,
    parameter int DEPTH = fdc_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import fdc_pkg::*;

    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
            $error("fdc_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    assign in_ready = count != (PW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PW'(1);
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : fdc_fifo

// ---- rtl/fdc_dev_end.sv ----
`timescale 1ns/10ps
module fdc_dev_end #(
    parameter int NUM_W = fdc_pkg::NUM_W,
    parameter int FIFO_DEPTH = fdc_pkg::FIFO_DEPTH,
    parameter int DRAIN_CYC = fdc_pkg::DRAIN_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    fdc_link_if.dev link,
    output logic [NUM_W-1:0] frac_numerator,
    output logic [fdc_pkg::STEP_W-1:0] applied_step,
    output logic set_active
);
    import fdc_pkg::*;

    localparam int PACE_W = $clog2(DRAIN_CYC + 1);

    initial begin
        if (NUM_W < STEP_W || DRAIN_CYC < 1 || DRAIN_CYC > 4096) begin
            $error("fdc_dev_end: NUM_W below step width or DRAIN_CYC out of range");
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [6:0] pin_raw;
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic [6:0] pin_prev;

    assign pin_raw = {link.ser_clk, link.ser_data, link.ser_cs_n, link.stream_clk,
                      link.stream_ws, link.symbol_pin_1, link.symbol_pin_0};

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            // Idle levels, so release of reset shows no false frame edge
            pin_meta <= 7'h10;
            pin_sync <= 7'h10;
            pin_prev <= 7'h10;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    logic s_sclk_rise;
    logic s_sdata;
    logic s_cs_n;
    logic s_cs_rise;
    logic s_stclk_rise;
    logic s_ws;
    logic s_ws_fall;
    logic [1:0] s_symbol;

    assign s_sclk_rise = pin_sync[6] && !pin_prev[6];
    assign s_sdata = pin_sync[5];
    assign s_cs_n = pin_sync[4];
    assign s_cs_rise = pin_sync[4] && !pin_prev[4];
    assign s_stclk_rise = pin_sync[3] && !pin_prev[3];
    assign s_ws = pin_sync[2];
    assign s_ws_fall = !pin_sync[2] && pin_prev[2];
    assign s_symbol = pin_sync[1:0];

    // ****************************************
    // Serial register write port
    // ****************************************
    logic [FRAME_BITS-1:0] ser_shift;
    logic [4:0] ser_bits;
    logic wr_stb;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ser_shift <= '0;
            ser_bits <= 5'h00;
        end else if (s_cs_n) begin
            ser_bits <= 5'h00;
        end else if (s_sclk_rise) begin
            ser_shift <= {ser_shift[FRAME_BITS-2:0], s_sdata};
            // Saturate past full length, so long frames never match
            if (ser_bits != 5'h1F) begin
                ser_bits <= ser_bits + 5'h01;
            end
        end
    end

    // Short or long frames are dropped, never half-applied
    assign wr_stb = s_cs_rise && ser_bits == 5'(FRAME_BITS);
    assign wr_addr = ser_shift[FRAME_BITS-1 -: ADDR_W];
    assign wr_data = ser_shift[DATA_W-1:0];

    // ****************************************
    // Configuration registers
    // ****************************************
    logic set_sel;
    fdc_mode_e mode;
    logic [2:0] level;
    logic [1:0] mod_enable;
    logic [2:0] deviation_index_select;
    logic [STEP_W-1:0] direct_step_value;
    logic [NUM_W-1:0] nominal [2];
    logic [STEP_W-1:0] dev_step [2][LEVELS_MAX];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            set_sel <= 1'b0;
            mode <= FDC_MODE_PIN;
            level <= 3'h0;
            mod_enable <= 2'h0;
            deviation_index_select <= 3'h0;
            direct_step_value <= REG_RESET;
            nominal <= '{default: '0};
            dev_step <= '{default: '{default: REG_RESET}};
        end else if (wr_stb) begin
            if (wr_addr == ADDR_CTRL) begin
                set_sel <= wr_data[CTRL_SET_SEL_BIT];
            end
            if (wr_addr == ADDR_MODE) begin
                mode <= fdc_mode_e'(wr_data[MODE_HI_BIT:MODE_LO_BIT]);
                level <= wr_data[LEVEL_MSB:LEVEL_LSB];
                mod_enable <= {wr_data[EN_B_BIT], wr_data[EN_A_BIT]};
            end
            if (wr_addr == ADDR_DEV_SEL) begin
                deviation_index_select <= wr_data[DEV_SEL_MSB:0];
            end
            if (wr_addr == ADDR_DIRECT) begin
                direct_step_value <= wr_data;
            end
            if (wr_addr == ADDR_NOM_A) begin
                nominal[0] <= NUM_W'(wr_data);
            end
            if (wr_addr == ADDR_NOM_B) begin
                nominal[1] <= NUM_W'(wr_data);
            end
            // Two banks of eight, one per frequency set
            if (wr_addr >= ADDR_BANK_A && wr_addr < ADDR_BANK_A + 8'(LEVELS_MAX)) begin
                dev_step[0][3'(wr_addr - ADDR_BANK_A)] <= wr_data;
            end
            if (wr_addr >= ADDR_BANK_B && wr_addr < ADDR_BANK_B + 8'(LEVELS_MAX)) begin
                dev_step[1][3'(wr_addr - ADDR_BANK_B)] <= wr_data;
            end
        end
    end

    // ****************************************
    // Serial stream receiver and buffer
    // ****************************************
    logic [STEP_W-1:0] st_shift;
    logic [4:0] st_bits;
    logic st_push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [STEP_W-1:0] fifo_out_data;
    logic [PACE_W-1:0] pace;
    logic [STEP_W-1:0] stream_step;
    logic stream_ready_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_shift <= '0;
            st_bits <= 5'h00;
        end else if (!s_ws) begin
            st_bits <= 5'h00;
        end else if (s_stclk_rise) begin
            st_shift <= {st_shift[STEP_W-2:0], s_symbol[1]};
            if (st_bits != 5'h1F) begin
                st_bits <= st_bits + 5'h01;
            end
        end
    end

    assign st_push = s_ws_fall && st_bits == 5'(STEP_W);

    fdc_fifo #(
        .WIDTH(STEP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(st_push),
        .in_ready(fifo_in_ready),
        .in_data(st_shift),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Drain is paced to a fixed sample rate, so bursts from the host fill the buffer
    assign fifo_out_ready = pace == '0;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pace <= '0;
            stream_step <= REG_RESET;
        end else if (fifo_out_valid && fifo_out_ready) begin
            pace <= PACE_W'(DRAIN_CYC - 1);
            stream_step <= fifo_out_data;
        end else if (pace != '0) begin
            pace <= pace - PACE_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stream_ready_q <= 1'b0;
        end else begin
            stream_ready_q <= fifo_in_ready;
        end
    end

    assign link.stream_ready = stream_ready_q;

    // ****************************************
    // Deviation selection and numerator
    // ****************************************
    logic [2:0] level_mask;
    logic [2:0] sel_index;
    logic [STEP_W-1:0] next_step;
    logic [NUM_W-1:0] next_numerator;

    // Level field is log2 of the symbol count; index bits above it are ignored
    assign level_mask = 3'((4'h1 << level) - 4'h1);

    always_comb begin
        sel_index = 3'h0;
        next_step = '0;
        unique case (mode)
            FDC_MODE_PIN: begin
                sel_index = {1'b0, s_symbol} & level_mask;
                next_step = dev_step[set_sel][sel_index];
            end
            FDC_MODE_REG: begin
                sel_index = deviation_index_select & level_mask;
                next_step = dev_step[set_sel][sel_index];
            end
            FDC_MODE_STREAM: begin
                next_step = stream_step;
            end
            FDC_MODE_DIRECT: begin
                next_step = direct_step_value;
            end
        endcase
        if (!mod_enable[set_sel]) begin
            next_step = '0;
        end
        // Sign extension makes stored two's complement steps pull the numerator down
        next_numerator = nominal[set_sel] + NUM_W'($signed(next_step));
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            frac_numerator <= '0;
            applied_step <= '0;
            set_active <= 1'b0;
        end else begin
            frac_numerator <= next_numerator;
            applied_step <= next_step;
            set_active <= set_sel;
        end
    end
endmodule : fdc_dev_end

// ---- rtl/fdc_host_end.sv ----
`timescale 1ns/10ps
module fdc_host_end #(
    parameter int HALF_CYC = fdc_pkg::LINK_HALF_CYC,
    parameter int GAP = fdc_pkg::GAP_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    fdc_link_if.host link,
    input wire logic reg_valid,
    output logic reg_ready,
    input wire logic [fdc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fdc_pkg::DATA_W-1:0] reg_data,
    input wire logic [1:0] sym_value,
    input wire logic stream_valid,
    output logic stream_ready,
    input wire logic [fdc_pkg::STEP_W-1:0] stream_step
);
    import fdc_pkg::*;

    initial begin
        // A shorter gap lets a stale ready overrun the far buffer
        if (HALF_CYC < 1 || HALF_CYC > 255 || GAP < 8 || GAP > 255) begin
            $error("fdc_host_end: HALF_CYC must lie in 1..255 and GAP in 8..255");
        end
    end

    logic rdy_meta;
    logic rdy_sync;
    fdc_tx_state_e state;
    fdc_tx_state_e next_state;
    logic [7:0] phase;
    logic [4:0] bits_left;
    logic [FRAME_BITS-1:0] shreg;
    logic is_stream;
    logic take_reg;
    logic take_st;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdy_meta <= 1'b0;
            rdy_sync <= 1'b0;
        end else begin
            rdy_meta <= link.stream_ready;
            rdy_sync <= rdy_meta;
        end
    end

    // Register writes win over stream words offered in the same cycle
    assign take_reg = reg_valid && reg_ready;
    assign take_st = stream_valid && stream_ready && !take_reg;

    always_comb begin
        next_state = state;
        unique case (state)
            FDC_TX_IDLE: begin
                if (take_reg || take_st) begin
                    next_state = FDC_TX_LOW;
                end
            end
            FDC_TX_LOW: begin
                if (phase == 8'h00) begin
                    next_state = FDC_TX_HIGH;
                end
            end
            FDC_TX_HIGH: begin
                if (phase == 8'h00) begin
                    next_state = (bits_left == 5'h01) ? FDC_TX_END : FDC_TX_LOW;
                end
            end
            FDC_TX_END: begin
                if (phase == 8'h00) begin
                    next_state = FDC_TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= FDC_TX_IDLE;
            phase <= 8'h00;
            bits_left <= 5'h00;
            shreg <= '0;
            is_stream <= 1'b0;
        end else begin
            state <= next_state;
            if (state == FDC_TX_IDLE) begin
                phase <= 8'(HALF_CYC - 1);
                if (take_reg) begin
                    shreg <= {reg_addr, reg_data};
                    bits_left <= 5'(FRAME_BITS);
                    is_stream <= 1'b0;
                end else if (take_st) begin
                    // Signed steps go out MSB first, as the controller computed them
                    shreg <= {stream_step, {(FRAME_BITS-STEP_W){1'b0}}};
                    bits_left <= 5'(STEP_W);
                    is_stream <= 1'b1;
                end
            end else if (phase != 8'h00) begin
                phase <= phase - 8'h01;
            end else if (state == FDC_TX_HIGH) begin
                shreg <= {shreg[FRAME_BITS-2:0], 1'b0};
                bits_left <= bits_left - 5'h01;
                phase <= (bits_left == 5'h01) ? 8'(GAP - 1) : 8'(HALF_CYC - 1);
            end else if (state == FDC_TX_LOW) begin
                phase <= 8'(HALF_CYC - 1);
            end
        end
    end

    // ****************************************
    // Pin and ready registers
    // ****************************************
    logic in_frame;

    assign in_frame = state == FDC_TX_LOW || state == FDC_TX_HIGH;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            link.ser_clk <= 1'b0;
            link.ser_data <= 1'b0;
            link.ser_cs_n <= 1'b1;
            link.stream_clk <= 1'b0;
            link.stream_ws <= 1'b0;
            link.symbol_pin_0 <= 1'b0;
            link.symbol_pin_1 <= 1'b0;
            reg_ready <= 1'b0;
            stream_ready <= 1'b0;
        end else begin
            link.ser_clk <= !is_stream && state == FDC_TX_HIGH;
            link.ser_data <= !is_stream && in_frame && shreg[FRAME_BITS-1];
            link.ser_cs_n <= !(!is_stream && in_frame);
            link.stream_clk <= is_stream && state == FDC_TX_HIGH;
            link.stream_ws <= is_stream && in_frame;
            link.symbol_pin_0 <= sym_value[0];
            // Stream data shares the second symbol pin
            link.symbol_pin_1 <= (is_stream && in_frame) ? shreg[FRAME_BITS-1] : sym_value[1];
            reg_ready <= next_state == FDC_TX_IDLE && !take_reg && !take_st;
            stream_ready <= next_state == FDC_TX_IDLE && !take_reg && !take_st && rdy_sync;
        end
    end
endmodule : fdc_host_end

// ---- bench/fdc_link_asserts.sv ----
`timescale 1ns/10ps
module fdc_link_asserts (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_cs_n,
    input wire logic symbol_pin_1,
    input wire logic stream_clk,
    input wire logic stream_ws
);
    // ********
    // Clock rises counted per frame and per word
    // ********
    logic ser_clk_q;
    logic stream_clk_q;
    logic [5:0] frame_rises;
    logic [4:0] word_rises;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ser_clk_q <= 1'b0;
            stream_clk_q <= 1'b0;
            frame_rises <= 6'h00;
            word_rises <= 5'h00;
        end else begin
            ser_clk_q <= ser_clk;
            stream_clk_q <= stream_clk;
            frame_rises <= ser_cs_n ? 6'h00 : frame_rises + {5'h00, ser_clk & ~ser_clk_q};
            word_rises <= !stream_ws ? 5'h00 : word_rises + {4'h0, stream_clk & ~stream_clk_q};
        end
    end

    // ********
    // Link properties
    // ********
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_wide(logic c);
        c [*4] ##1 !c;
    endsequence

    a_clk_idle_low: assert property (ser_cs_n |-> !ser_clk)
        else $error("serial clock active outside frame");
    a_data_held_high: assert property (ser_clk |-> $stable(ser_data))
        else $error("serial data moved while clock high");
    a_clk_half_wide: assert property ($rose(ser_clk) |-> s_wide(ser_clk))
        else $error("serial clock high phase wrong length");
    a_frame_24_rises: assert property ($rose(ser_cs_n) |-> frame_rises == 6'h18)
        else $error("frame did not carry 24 clock rises");
    a_frame_gap: assert property ($rose(ser_cs_n) |-> ser_cs_n [*8])
        else $error("frames too close together");
    a_stream_clk_idle: assert property (!stream_ws |-> !stream_clk)
        else $error("stream clock active outside word");
    a_stream_bit_held: assert property (stream_clk |-> $stable(symbol_pin_1))
        else $error("stream data moved while clock high");
    a_word_16_rises: assert property ($fell(stream_ws) |-> word_rises == 5'h10)
        else $error("stream word did not carry 16 rises");
    a_stream_clk_wide: assert property ($rose(stream_clk) |-> s_wide(stream_clk))
        else $error("stream clock high phase wrong length");
endmodule : fdc_link_asserts

// ---- bench/fdc_deviation_control_bench.sv ----
`timescale 1ns/10ps
module fsk_deviation_control_bench;
    import fdc_pkg::*;
    // Slow drain so the 8-word buffer really fills
    localparam int DRAIN = 1024;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_valid = 1'b0;
    logic reg_ready;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_data = 16'h0000;
    logic [1:0] sym_value = 2'h0;
    logic stream_valid = 1'b0;
    logic stream_ready;
    logic [STEP_W-1:0] stream_step = 16'h0000;
    logic [NUM_W-1:0] frac_numerator;
    logic [STEP_W-1:0] applied_step;
    logic set_active;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic mon = 1'b0;
    logic saw_full = 1'b0;
    logic [STEP_W-1:0] got[$];
    logic [STEP_W-1:0] last;

    fdc_link_if fdc_link_if_inst ();
    fdc_host_end fdc_host_end_inst (.core_clk(core_clk), .nrst(nrst), .link(fdc_link_if_inst),
        .reg_valid(reg_valid), .reg_ready(reg_ready), .reg_addr(reg_addr), .reg_data(reg_data),
        .sym_value(sym_value), .stream_valid(stream_valid), .stream_ready(stream_ready),
        .stream_step(stream_step));
    fdc_dev_end #(.DRAIN_CYC(DRAIN)) fdc_dev_end_inst (.core_clk(core_clk), .nrst(nrst),
        .link(fdc_link_if_inst), .frac_numerator(frac_numerator), .applied_step(applied_step),
        .set_active(set_active));
    fdc_link_asserts fdc_link_asserts_inst (.core_clk(core_clk), .nrst(nrst),
        .ser_clk(fdc_link_if_inst.ser_clk), .ser_data(fdc_link_if_inst.ser_data),
        .ser_cs_n(fdc_link_if_inst.ser_cs_n), .symbol_pin_1(fdc_link_if_inst.symbol_pin_1),
        .stream_clk(fdc_link_if_inst.stream_clk), .stream_ws(fdc_link_if_inst.stream_ws));

    always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

    // Sampled mid-cycle, away from the edge that launches the outputs
    always @(negedge core_clk) begin
        if (!mon) begin
            last = applied_step;
        end else if (applied_step !== last) begin
            got.push_back(applied_step);
            last = applied_step;
        end
        if (mon && fdc_link_if_inst.stream_ready === 1'b0) begin
            saw_full = 1'b1;
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 45000) begin
            errors++;
            $display("ERROR run_length expected finish seen hang");
            end_sim();
        end
    end

    // ********
    // Shared tasks
    // ********
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        while (reg_ready !== 1'b1) tick(1);
        reg_addr = a;
        reg_data = d;
        reg_valid = 1'b1;
        tick(1);
        reg_valid = 1'b0;
        while (reg_ready !== 1'b1) tick(1);
        tick(6);
    endtask : wr

    task automatic push(input logic [STEP_W-1:0] w);
        while (stream_ready !== 1'b1) tick(1);
        stream_step = w;
        stream_valid = 1'b1;
        tick(1);
        stream_valid = 1'b0;
    endtask : push

    // Low indices negative, so signed handling shows
    function automatic logic [15:0] step_of(input int i);
        return 16'(i * 256 - 768);
    endfunction : step_of

    // ********
    // Scenarios
    // ********
    task automatic test_pin();
        for (int i = 0; i < 8; i++) wr(8'(ADDR_BANK_A + i), step_of(i));
        wr(ADDR_NOM_A, 16'h1000);
        wr(ADDR_MODE, 16'h0028);
        for (int s = 0; s < 4; s++) begin
            sym_value = 2'(s);
            tick(6);
            chk("pin_step", applied_step, step_of(s));
            chk("pin_num", frac_numerator, 16'h1000 + step_of(s));
        end
        sym_value = 2'h0;
        $display("test pin done");
    endtask : test_pin

    task automatic test_reg();
        wr(ADDR_MODE, 16'h002D);
        for (int i = 7; i >= 0; i--) begin
            wr(ADDR_DEV_SEL, 16'(i));
            chk("reg_step", applied_step, step_of(i));
        end
        $display("test register select done");
    endtask : test_reg

    task automatic test_set_b();
        wr(ADDR_BANK_B, 16'h0040);
        wr(ADDR_NOM_B, 16'h2000);
        wr(ADDR_MODE, 16'h004D);
        wr(ADDR_CTRL, 16'h0040);
        chk("set_b", {15'h0000, set_active}, 16'h0001);
        chk("num_b", frac_numerator, 16'h2040);
        wr(ADDR_CTRL, 16'h0000);
        chk("set_a", {15'h0000, set_active}, 16'h0000);
        chk("num_a_off", frac_numerator, 16'h1000);
        $display("test set switch done");
    endtask : test_set_b

    task automatic test_direct();
        logic [15:0] v[3] = '{16'hFAB2, 16'h068E, 16'hF971};
        wr(ADDR_MODE, 16'h0023);
        foreach (v[i]) begin
            wr(ADDR_DIRECT, v[i]);
            chk("direct_step", applied_step, v[i]);
            chk("direct_num", frac_numerator, 16'h1000 + v[i]);
        end
        $display("test direct done");
    endtask : test_direct

    task automatic test_stream();
        wr(ADDR_MODE, 16'h0022);
        mon = 1'b1;
        for (int k = 1; k <= 14; k++) push(16'(k * 16'h0111));
        while (got.size() < 14) tick(1);
        tick(2 * DRAIN);
        chk("words", 16'(got.size()), 16'h000E);
        foreach (got[k]) chk("stream_step", got[k], 16'((k + 1) * 16'h0111));
        chk("buffer_full_seen", {15'h0000, saw_full}, 16'h0001);
        chk("buffer_empty", {15'h0000, fdc_link_if_inst.stream_ready}, 16'h0001);
        mon = 1'b0;
        $display("test stream done");
    endtask : test_stream

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (3) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        tick(2);
        chk("reset_num", frac_numerator, 16'h0000);
        $display("test reset done");
        test_pin();
        test_reg();
        test_set_b();
        test_direct();
        test_stream();
        end_sim();
    end
endmodule : fsk_deviation_control_bench
